// ### rtl/sdc_pkg.sv
// Constants for the stall detection block: register map, field layout and timing.
// Assumes a single 20 MHz clock and an APB master for software access.
package sdc_pkg;
  localparam int CLOCK_HZ = 20000000;
  localparam int ADDR_W = 8;
  // Register byte offsets.
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_OTP = 8'h04;
  localparam logic [7:0] OFF_STATUS = 8'h08;
  localparam logic [7:0] OFF_CMD = 8'h0C;
  localparam logic [7:0] OFF_POS = 8'h10;
  localparam logic [7:0] OFF_IRQ_STAT = 8'h14;
  localparam logic [7:0] OFF_IRQ_EN = 8'h18;
  localparam logic [7:0] OFF_IRQ_CLR = 8'h1C;
  localparam logic [7:0] OFF_BEMF = 8'h20;
  // Parameter field positions, shared by control and OTP registers.
  localparam int THR_LSB = 0;
  localparam int DLY_LSB = 4;
  localparam int ACT_LSB = 8;
  localparam int FDE_BIT = 11;
  localparam logic [11:0] OTP_RESET = 12'h000;
  // Command register bits.
  localparam int CMD_FULL = 0;
  localparam int CMD_SHORT = 1;
  localparam int CMD_PARAM = 2;
  localparam int CMD_OTP = 3;
  // Status bits and interrupt event bits.
  localparam int ST_LOSS = 0;
  localparam int ST_STALL = 1;
  localparam int ST_TRIP = 2;
  localparam int ST_HALT = 3;
  localparam int ST_ARMED = 4;
  localparam int IRQ_W = 3;
  localparam int POS_W = 16;
  localparam int BEMF_W = 10;
  // Threshold levels in millivolts for codes 0 to F.
  localparam int LEVEL_MV [16] = '{0, 640, 1280, 1920, 2560, 3190, 3830, 4470,
    5110, 5750, 6380, 7030, 7670, 8300, 8940, 9580};
  localparam int BEMF_FULL_MV = 10230;
  // Sample delays in microseconds for codes 0 to 7.
  localparam int DELAY_US [8] = '{87, 130, 174, 217, 304, 391, 521, 694};
  localparam int DLY_W = 14;
  typedef enum logic [1:0] {
    SDC_IDLE = 2'b00,
    SDC_WAIT = 2'b01,
    SDC_SAMPLE = 2'b10
  } sdc_state_type;
endpackage

// ### rtl/sdc_stall_detect.sv
// Stall detection with APB registers, delay timer, flags and interrupt.
// Assumes motor status inputs come from logic on the same clock and the back-emf
// code is a linear ADC word with full scale at BEMF_FULL_MV.
//
// The register offsets and the APB interface to the registers were decided locally.
`timescale 1ns/1ns
`default_nettype none
module sdc_stall_detect
  import sdc_pkg::*;
(
  input wire logic clock,
  input wire logic reset_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic zero_cross,
  input wire logic [BEMF_W-1:0] bemf_sample,
  input wire logic at_max_velocity,
  input wire logic positioning,
  input wire logic full_step,
  input wire logic full_duty,
  input wire logic [POS_W-1:0] internal_position,
  output logic hard_stop,
  output logic positioning_allowed,
  output logic irq
);
  function automatic logic [BEMF_W-1:0] level_code(input logic [3:0] code);
    level_code = BEMF_W'((LEVEL_MV[code] * ((1 << BEMF_W) - 1)) / BEMF_FULL_MV);
  endfunction
  function automatic logic [DLY_W-1:0] delay_cycles(input logic [2:0] code);
    delay_cycles = DLY_W'((DELAY_US[code] * (CLOCK_HZ / 1000000)) - 1);
  endfunction

  logic [11:0] otp_param;
  logic [11:0] ram_param;
  logic loaded;
  logic step_loss;
  logic stall;
  logic trip;
  logic halted;
  logic armed;
  logic [2:0] step_count;
  logic [POS_W-1:0] actual_position;
  logic [DLY_W-1:0] delay_count;
  logic [BEMF_W-1:0] bemf_latch;
  logic [IRQ_W-1:0] irq_stat;
  logic [IRQ_W-1:0] irq_en;
  sdc_state_type state;
  sdc_state_type next_state;

  wire logic wr = psel && penable && pwrite;
  wire logic rd = psel && penable && !pwrite;
  wire logic wr_ctrl = wr && paddr == OFF_CTRL;
  wire logic wr_cmd = wr && paddr == OFF_CMD;
  wire logic wr_en = wr && paddr == OFF_IRQ_EN;
  wire logic wr_clr = wr && paddr == OFF_IRQ_CLR;
  wire logic cmd_full = (wr_cmd && pwdata[CMD_FULL]) || (rd && paddr == OFF_STATUS);
  wire logic cmd_short = wr_cmd && pwdata[CMD_SHORT] && !cmd_full;
  wire logic cmd_param = (wr_cmd && pwdata[CMD_PARAM]) || wr_ctrl;
  wire logic cmd_otp = (wr_cmd && pwdata[CMD_OTP]) || (wr && paddr == OFF_OTP);
  wire logic mapped = paddr == OFF_CTRL || paddr == OFF_OTP || paddr == OFF_STATUS
    || paddr == OFF_CMD || paddr == OFF_POS || paddr == OFF_IRQ_STAT
    || paddr == OFF_IRQ_EN || paddr == OFF_IRQ_CLR || paddr == OFF_BEMF;
  wire logic [3:0] bemf_threshold_code = ram_param[THR_LSB +: 4];
  wire logic [2:0] sample_delay_code = ram_param[DLY_LSB +: 3];
  wire logic [2:0] detect_activation_steps = ram_param[ACT_LSB +: 3];
  wire logic full_duty_detect_enable = ram_param[FDE_BIT];
  wire logic detect_on = bemf_threshold_code != 4'h0;
  wire logic duty_ok = !full_duty || full_duty_detect_enable;
  wire logic run_ok = detect_on && armed && at_max_velocity && duty_ok;
  wire logic take_sample = state == SDC_SAMPLE;
  wire logic below = bemf_latch < level_code(bemf_threshold_code);
  wire logic stall_event = take_sample && run_ok && below;
  wire logic hard_event = stall_event && positioning;
  wire logic [IRQ_W-1:0] events = {stall_event, stall_event, hard_event};
  wire logic [7:0] status_word = {3'h0, armed, halted, trip, stall, step_loss};

  // Sample delay state machine.
  always_comb begin
    next_state = state;
    unique case (state)
      SDC_IDLE: begin
        if (zero_cross && detect_on) begin
          next_state = SDC_WAIT;
        end
      end
      SDC_WAIT: begin
        if (!detect_on) begin
          next_state = SDC_IDLE;
        end else if (delay_count == '0) begin
          next_state = SDC_SAMPLE;
        end
      end
      SDC_SAMPLE: next_state = SDC_IDLE;
    endcase
  end

  always_ff @(posedge clock) begin
    if (!reset_n) begin
      state <= SDC_IDLE;
      delay_count <= '0;
      bemf_latch <= '0;
    end else begin
      state <= next_state;
      if (state == SDC_IDLE && zero_cross) begin
        delay_count <= delay_cycles(sample_delay_code);
      end else if (delay_count != '0) begin
        delay_count <= delay_count - 1'b1;
      end
      if (state == SDC_WAIT && delay_count == '0) begin
        bemf_latch <= bemf_sample;
      end
    end
  end

  // Arming after the ramp; any speed change disarms again.
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      armed <= 1'b0;
      step_count <= '0;
    end else if (!at_max_velocity || !detect_on) begin
      armed <= 1'b0;
      step_count <= '0;
    end else if (!armed) begin
      if (step_count == detect_activation_steps) begin
        armed <= 1'b1;
      end else if (full_step) begin
        step_count <= step_count + 1'b1;
      end
    end
  end

  // Parameters. OTP contents survive only as long as this storage, a model trade-off.
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      otp_param <= OTP_RESET;
      ram_param <= OTP_RESET;
      loaded <= 1'b0;
    end else begin
      loaded <= 1'b1;
      if (!loaded) begin
        ram_param <= otp_param;
      end else if (cmd_param) begin
        ram_param <= pwdata[11:0];
      end
      if (cmd_otp) begin
        otp_param <= pwdata[11:0];
      end
    end
  end

  // Flags: a new event in the clear cycle wins.
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      step_loss <= 1'b0;
      stall <= 1'b0;
      trip <= 1'b0;
      halted <= 1'b0;
      actual_position <= '0;
    end else begin
      if (hard_event) begin
        step_loss <= 1'b1;
        halted <= 1'b1;
        actual_position <= internal_position;
      end else if (cmd_full || cmd_short) begin
        step_loss <= 1'b0;
        halted <= 1'b0;
      end
      if (!halted && !hard_event) begin
        actual_position <= internal_position;
      end
      if (stall_event) begin
        stall <= 1'b1;
        trip <= 1'b1;
      end else if (cmd_full) begin
        stall <= 1'b0;
        trip <= 1'b0;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (!reset_n) begin
      irq_stat <= '0;
      irq_en <= '0;
    end else begin
      irq_stat <= (irq_stat & ~(wr_clr ? pwdata[IRQ_W-1:0] : '0)) | events;
      if (wr_en) begin
        irq_en <= pwdata[IRQ_W-1:0];
      end
    end
  end

  // Read data is registered in the setup cycle so it stands in the access cycle.
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      prdata <= '0;
    end else if (psel && !penable && !pwrite) begin
      unique case (paddr)
        OFF_CTRL: prdata <= {20'h00000, ram_param};
        OFF_OTP: prdata <= {20'h00000, otp_param};
        OFF_STATUS: prdata <= {24'h000000, status_word};
        OFF_POS: prdata <= {16'h0000, actual_position};
        OFF_IRQ_STAT: prdata <= {29'h00000000, irq_stat};
        OFF_IRQ_EN: prdata <= {29'h00000000, irq_en};
        OFF_BEMF: prdata <= {22'h000000, bemf_latch};
        default: prdata <= '0;
      endcase
    end
  end

  assign pready = 1'b1;
  assign pslverr = psel && penable && !mapped;
  assign hard_stop = halted;
  assign positioning_allowed = !halted;
  assign irq = |(irq_stat & irq_en);

  // Checker helper: counts wait cycles against the delay code taken at entry.
  // The code is held here because software may rewrite it while a wait runs.
  logic [DLY_W-1:0] wait_len;
  logic [2:0] wait_code;

  always_ff @(posedge clock) begin
    if (!reset_n) begin
      wait_len <= '0;
      wait_code <= 3'h0;
    end else if (state == SDC_IDLE && next_state == SDC_WAIT) begin
      wait_len <= '0;
      wait_code <= sample_delay_code;
    end else if (state == SDC_WAIT) begin
      wait_len <= wait_len + 1'b1;
    end
  end

  a_trip_sets_stall: assert property (@(posedge clock) disable iff (!reset_n)
    stall_event |=> stall && trip) else $error("stall flags not set");
  a_zero_disables: assert property (@(posedge clock) disable iff (!reset_n)
    bemf_threshold_code == 4'h0 |-> !stall_event) else $error("stall while off");
  a_full_duty_gate: assert property (@(posedge clock) disable iff (!reset_n)
    full_duty && !full_duty_detect_enable |-> !stall_event) else $error("duty gate");
  a_speed_gate: assert property (@(posedge clock) disable iff (!reset_n)
    !at_max_velocity |=> !armed) else $error("armed off speed");
  a_hard_stop_copy: assert property (@(posedge clock) disable iff (!reset_n)
    hard_event |=> halted && step_loss && actual_position == $past(internal_position))
    else $error("hard stop incomplete");
  a_full_clears: assert property (@(posedge clock) disable iff (!reset_n)
    cmd_full && !stall_event |=> !stall && !trip && !step_loss) else $error("full clear");
  a_short_keeps: assert property (@(posedge clock) disable iff (!reset_n)
    cmd_short && !stall_event |=> stall == $past(stall) && !step_loss && !halted)
    else $error("short clear");
  a_delay_wait: assert property (@(posedge clock) disable iff (!reset_n)
    state == SDC_IDLE && zero_cross && detect_on && sample_delay_code == 3'h0
    |=> state == SDC_WAIT [*8]) else $error("sample too early");
  a_otp_load: assert property (@(posedge clock) disable iff (!reset_n)
    !loaded |=> ram_param == $past(otp_param)) else $error("otp not copied");
  a_arm_steps: assert property (@(posedge clock) disable iff (!reset_n)
    $rose(armed) |-> step_count == detect_activation_steps) else $error("arm early");
  a_irq_level: assert property (@(posedge clock) disable iff (!reset_n)
    stall_event && irq_en[1] |=> irq) else $error("irq missing");

  // Sample timing.
  a_delay_length: assert property (@(posedge clock) disable iff (!reset_n)
    state == SDC_WAIT && next_state == SDC_SAMPLE |-> wait_len == delay_cycles(wait_code))
    else $error("delay length wrong");
  a_sample_latch: assert property (@(posedge clock) disable iff (!reset_n)
    state == SDC_WAIT && next_state == SDC_SAMPLE |=> bemf_latch == $past(bemf_sample))
    else $error("sample not latched");
  a_sample_single: assert property (@(posedge clock) disable iff (!reset_n)
    state == SDC_SAMPLE |=> state == SDC_IDLE)
    else $error("sample repeated");
  a_zero_idles: assert property (@(posedge clock) disable iff (!reset_n)
    !detect_on |=> state == SDC_IDLE)
    else $error("timer runs while off");

  // Arming.
  a_arm_needs_speed: assert property (@(posedge clock) disable iff (!reset_n)
    armed |-> $past(at_max_velocity))
    else $error("armed without speed");
  a_arm_needs_thr: assert property (@(posedge clock) disable iff (!reset_n)
    armed |-> $past(detect_on))
    else $error("armed while off");
  a_step_restart: assert property (@(posedge clock) disable iff (!reset_n)
    !at_max_velocity || !detect_on |=> step_count == 3'h0)
    else $error("step count kept");

  // Flags and position.
  a_position_track: assert property (@(posedge clock) disable iff (!reset_n)
    !halted && !hard_event |=> actual_position == $past(internal_position))
    else $error("position not tracked");
  a_halt_holds_pos: assert property (@(posedge clock) disable iff (!reset_n)
    halted && !hard_event |=> actual_position == $past(actual_position))
    else $error("position moved while halted");
  a_stall_holds: assert property (@(posedge clock) disable iff (!reset_n)
    stall && !cmd_full |=> stall)
    else $error("stall lost");
  a_trip_holds: assert property (@(posedge clock) disable iff (!reset_n)
    trip && !cmd_full |=> trip)
    else $error("trip lost");
  a_loss_holds: assert property (@(posedge clock) disable iff (!reset_n)
    step_loss && !cmd_full && !cmd_short |=> step_loss)
    else $error("step loss lost");
  a_halt_release: assert property (@(posedge clock) disable iff (!reset_n)
    halted && (cmd_full || cmd_short) && !hard_event |=> positioning_allowed)
    else $error("halt not released");
  a_hard_needs_move: assert property (@(posedge clock) disable iff (!reset_n)
    $rose(halted) |-> $past(positioning))
    else $error("halt without move");
  a_stall_needs_low: assert property (@(posedge clock) disable iff (!reset_n)
    $rose(stall) |-> $past(below))
    else $error("stall above level");
  a_stall_duty: assert property (@(posedge clock) disable iff (!reset_n)
    $rose(stall) && $past(full_duty) |-> $past(full_duty_detect_enable))
    else $error("stall at full duty");
  a_stall_speed: assert property (@(posedge clock) disable iff (!reset_n)
    $rose(stall) |-> $past(at_max_velocity))
    else $error("stall off speed");

  // Parameters and interrupt.
  a_param_write: assert property (@(posedge clock) disable iff (!reset_n)
    cmd_param && loaded |=> ram_param == $past(pwdata[11:0]))
    else $error("param not written");
  a_otp_write: assert property (@(posedge clock) disable iff (!reset_n)
    cmd_otp |=> otp_param == $past(pwdata[11:0]))
    else $error("otp not written");
  a_loaded_once: assert property (@(posedge clock) disable iff (!reset_n)
    loaded |=> loaded)
    else $error("otp copied twice");
  a_irq_clear: assert property (@(posedge clock) disable iff (!reset_n)
    wr_clr && pwdata[IRQ_W-1:0] == {IRQ_W{1'b1}} && events == '0 |=> irq_stat == '0)
    else $error("irq not cleared");
endmodule
`default_nettype wire

// ### sim/sdc_motor_model.sv
// Motor side stand-in: full-step pulses while cruising, back-emf code to the block.
// Assumes the bench drives cruise and the wanted code on the block's clock.
`timescale 1ns/1ns
`default_nettype none
module sdc_motor_model
  import sdc_pkg::*;
(
  input wire logic clock,
  input wire logic reset_n,
  input wire logic cruise,
  input wire logic [BEMF_W-1:0] bemf_code,
  output logic full_step,
  output logic [BEMF_W-1:0] bemf_sample
);
  logic [2:0] phase;
  // Off cruise the code wanders so a stale value cannot pass for a real one.
  assign bemf_sample = cruise ? bemf_code : bemf_code ^ {7'h00, phase};
  assign full_step = cruise && (phase == 3'h7);
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      phase <= 3'h0;
    end else begin
      phase <= phase + 3'h1;
    end
  end
endmodule
`default_nettype wire

// ### sim/stall_detection_control_tb_top.sv
// Self-checking bench: APB register traffic plus motor stimulus.
// Assumes zero-wait APB answers and a detection delay near 1740 cycles for code 0.
`timescale 1ns/1ns
`default_nettype none
`define CHK(n, e, a) begin n_checks++; if ((a) !== (e)) begin bad_count++; \
  $display("mismatch %s expected %h seen %h", n, e, a); end end
module stall_detection_control_tb_top
  import sdc_pkg::*;
;
  logic clock, reset_n, psel, penable, pwrite, pready, pslverr, zero_cross;
  logic at_max_velocity, positioning, full_step, full_duty, hard_stop;
  logic positioning_allowed, irq;
  logic [ADDR_W-1:0] paddr;
  logic [31:0] pwdata, prdata, q;
  logic [BEMF_W-1:0] bemf_sample, bemf_code;
  logic [POS_W-1:0] internal_position;
  int bad_count = 0;
  int n_checks = 0;
  sdc_motor_model sdc_motor_model_inst (.clock(clock), .reset_n(reset_n),
    .cruise(at_max_velocity), .bemf_code(bemf_code), .full_step(full_step),
    .bemf_sample(bemf_sample));
  sdc_stall_detect sdc_stall_detect_inst (.clock(clock), .reset_n(reset_n), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .zero_cross(zero_cross),
    .bemf_sample(bemf_sample), .at_max_velocity(at_max_velocity),
    .positioning(positioning), .full_step(full_step), .full_duty(full_duty),
    .internal_position(internal_position), .hard_stop(hard_stop),
    .positioning_allowed(positioning_allowed), .irq(irq));
  initial begin
    clock = 1'b0;
    forever #25 clock = ~clock;
  end
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
    output logic err);
    int i;
    @(posedge clock);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    for (i = 0; i < 20; i++) begin
      @(posedge clock);
      if (pready === 1'b1) break;
    end
    if (i == 20) begin
      bad_count++;
      wrap_up();
    end
    q = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic e;
    xfer(1'b1, a, d, e);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    logic x;
    xfer(1'b0, a, 32'h0, x);
    `CHK("read data", e, q)
  endtask
  // One zero crossing; no stop may show before the delay, the expected one after it.
  task automatic probe(input logic [9:0] b, input logic stop);
    bemf_code <= b;
    @(posedge clock);
    zero_cross <= 1'b1;
    @(posedge clock);
    zero_cross <= 1'b0;
    repeat (1700) @(posedge clock);
    #1 `CHK("early stop", 1'b0, hard_stop)
    repeat (100) @(posedge clock);
    #1 `CHK("hard stop", stop, hard_stop)
  endtask
  initial begin
    logic e;
    {reset_n, psel, penable, pwrite, zero_cross, full_duty} = 6'h00;
    {at_max_velocity, positioning} = 2'b11;
    paddr = 8'h00;
    pwdata = 32'h0;
    bemf_code = 10'h000;
    internal_position = 16'h0000;
    repeat (2) @(posedge clock);
    reset_n <= 1'b1;
    rd(OFF_CTRL, 32'h0);
    wr(OFF_IRQ_EN, 32'h7);
    probe(10'h000, 1'b0);
    wr(OFF_OTP, 32'hA5);
    rd(OFF_OTP, 32'hA5);
    wr(OFF_CTRL, 32'h201);
    rd(OFF_CTRL, 32'h201);
    probe(10'h040, 1'b0);
    full_duty <= 1'b1;
    probe(10'h000, 1'b0);
    full_duty <= 1'b0;
    at_max_velocity <= 1'b0;
    probe(10'h000, 1'b0);
    at_max_velocity <= 1'b1;
    internal_position <= 16'h1234;
    repeat (40) @(posedge clock);
    probe(10'h03F, 1'b1);
    `CHK("irq", 1'b1, irq)
    `CHK("allowed", 1'b0, positioning_allowed)
    internal_position <= 16'h5678;
    rd(OFF_POS, 32'h1234);
    wr(OFF_CMD, 32'h2);
    #1 `CHK("allowed", 1'b1, positioning_allowed)
    rd(OFF_POS, 32'h5678);
    rd(OFF_STATUS, 32'h16);
    rd(OFF_STATUS, 32'h10);
    wr(OFF_IRQ_CLR, 32'h7);
    #1 `CHK("irq", 1'b0, irq)
    wr(OFF_CTRL, 32'hA01);
    full_duty <= 1'b1;
    probe(10'h000, 1'b1);
    wr(OFF_IRQ_EN, 32'h0);
    #1 `CHK("irq", 1'b0, irq)
    wr(OFF_CMD, 32'h1);
    rd(OFF_STATUS, 32'h10);
    positioning <= 1'b0;
    probe(10'h000, 1'b0);
    rd(OFF_STATUS, 32'h16);
    xfer(1'b0, 8'h40, 32'h0, e);
    `CHK("slverr", 1'b1, e)
    `CHK("read data", 32'h0, q)
    wrap_up();
  end
endmodule
`default_nettype wire
